// ---- bench/sfrpe_core_tb.sv ----
/* Self-checking bench of the flash sequencer with a host model.
   Assumes the package and the host model are compiled first. */
`timescale 1ns/1ps
module sfrpe_core_tb;
  logic                      clk_sys = 1'b0;
  logic                      arst_n = 1'b0;
  logic [2:0]                bp = 3'h0;
  logic                      oe_seen;
  logic [7:0]                exp_q[$];
  logic [7:0]                d[3];
  logic [31:0]               seed = 32'h2709;
  logic [23:0]               pa;
  int                        n_errors = 0;
  int                        checked = 0;
  logic                      cs_n, sck, si, si_w, so_w, rx_valid;
  logic [7:0]                rx_byte;
  sfrpe_pkg::sfrpe_pin_in_t  pins_in;
  sfrpe_pkg::sfrpe_pin_out_t pins_out;
  sfrpe_pkg::sfrpe_stat_t    st;

  always #2 clk_sys = ~clk_sys;
  assign si_w = pins_out.si_oe_n ? si : pins_out.si_out;
  // Released SO shows the inverse of its last bit
  assign so_w = pins_out.so_oe_n ? !pins_out.so : pins_out.so;
  assign pins_in = '{cs_n: cs_n, sck: sck, si: si_w};

  sfrpe_core u_sfrpe_core (
    .clk_sys(clk_sys), .arst_n(arst_n), .pins_in(pins_in), .pins_out(pins_out),
    .block_protect_0(bp[0]), .block_protect_1(bp[1]), .block_protect_2(bp[2]),
    .flash_status(st)
  );
  sfrpe_host u_sfrpe_host (
    .clk_sys(clk_sys), .so(so_w), .si_w(si_w), .cs_n(cs_n), .sck(sck),
    .si(si), .rx_valid(rx_valid), .rx_byte(rx_byte)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic fail(input string m);
    n_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask : fail

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) fail($sformatf("read %h, expected %h", g, e));
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) fail("status or timing mismatch");
  endtask : chk1

  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Output watcher: each received byte against the oldest note
  always @(posedge clk_sys) begin
    if (pins_out.so_oe_n === 1'b0) oe_seen = 1'b1;
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected byte");
      else chk8(rx_byte, exp_q.pop_front());
    end
  end

  task automatic write_latch_set_cmd;
    u_sfrpe_host.frame(8'h06, 24'h0, 0, 0, 0, 0, 0);
  endtask : write_latch_set_cmd

  task automatic wait_idle(input int n, input int slack);
    int c;
    c = 0;
    while (st.write_in_progress === 1'b1 && c < 70000) begin
      @(posedge clk_sys);
      c++;
    end
    chk1(c >= n - slack && c <= n, 1'b1);
  endtask : wait_idle

  task automatic refused(input logic [7:0] op, input logic [23:0] a, input int tail,
                         input bit pd);
    write_latch_set_cmd();
    if (pd) u_sfrpe_host.tx_q.push_back(8'h00);
    u_sfrpe_host.frame(op, a, 3, 0, 0, 0, tail);
    chk1(st.write_in_progress, 1'b0);
  endtask : refused

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk1(st.write_enable_latch, 1'b0);
    write_latch_set_cmd();
    chk1(st.write_enable_latch, 1'b1);
    u_sfrpe_host.frame(8'h20, 24'h000123, 3, 0, 0, 0, 0);
    chk1(st.write_in_progress, 1'b1);
    chk1(st.write_enable_latch, 1'b0);
    oe_seen = 1'b0;
    u_sfrpe_host.frame(8'h03, 24'h0, 3, 0, 0, 0, 16);
    chk1(oe_seen, 1'b0);
    // The 48-bit refused read frame runs inside the erase
    wait_idle(4096 - 48 * 20, 40);
    exp_q = '{8'hFF, 8'hFF, 8'hFF};
    u_sfrpe_host.frame(8'h03, 24'h0000FE, 3, 0, 3, 0, 0);
    write_latch_set_cmd();
    foreach (d[i]) begin
      seed = lfsr(seed);
      d[i] = seed[7:0];
      u_sfrpe_host.tx_q.push_back(d[i]);
    end
    u_sfrpe_host.frame(8'h02, 24'h0000FE, 3, 0, 0, 0, 0);
    chk1(st.write_enable_latch, 1'b0);
    wait_idle(256, 24);
    exp_q = '{d[0], d[1], 8'hFF};
    u_sfrpe_host.frame(8'h0B, 24'h0000FE, 3, 1, 3, 0, 0);
    exp_q = '{d[1], 8'hFF};
    u_sfrpe_host.frame(8'h3B, 24'h0000FF, 3, 1, 2, 1, 0);
    exp_q = '{d[2], 8'hFF};
    u_sfrpe_host.frame(8'h03, 24'h000000, 3, 0, 2, 0, 0);
    u_sfrpe_host.tx_q.push_back(8'h00);
    u_sfrpe_host.frame(8'h02, 24'h000200, 3, 0, 0, 0, 0);
    chk1(st.write_in_progress, 1'b0);
    refused(8'h02, 24'h000200, 4, 1);
    refused(8'h20, 24'h000000, 1, 0);
    seed = lfsr(seed);
    pa = {13'h003F, seed[10:0]};
    bp <= 3'h1;
    refused(8'h20, pa, 0, 0);
    refused(8'h52, pa, 0, 0);
    refused(8'hD8, 24'h010000, 0, 0);
    refused(8'h02, pa, 0, 1);
    bp <= 3'h0;
    write_latch_set_cmd();
    u_sfrpe_host.frame(8'h52, 24'h004567, 3, 0, 0, 0, 0);
    exp_q = '{8'h01};
    u_sfrpe_host.frame(8'h05, 24'h0, 0, 0, 1, 0, 0);
    wait_idle(32768, 420);
    exp_q = '{8'hFF, 8'hFF};
    u_sfrpe_host.frame(8'h03, 24'h0000FE, 3, 0, 2, 0, 0);
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail("timeout");
    tally_and_finish();
  end
endmodule : sfrpe_core_tb

// ---- bench/sfrpe_host.sv ----
/* Host controller model: mode 0 frames on cs_n, sck, si.
   Assumes clk_sys at 4 ns; sck period is 20 clk_sys cycles. */
`timescale 1ns/1ps
module sfrpe_host (
  input  wire logic  clk_sys,
  input  wire logic  so,
  input  wire logic  si_w,
  output logic       cs_n,
  output logic       sck,
  output logic       si,
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  logic [7:0] tx_q[$];

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // Set while low, sample at rise; a released line toggles
  task automatic sh(input logic [7:0] b, input int n, input bit rd, input bit dual);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      sck <= 1'b0;
      si <= rd ? ~si : b[3'(7 - i)];
      repeat (10) @(posedge clk_sys);
      sck <= 1'b1;
      r = dual ? {r[5:0], so, si_w} : {r[6:0], so};
      rx_byte <= r;
      rx_valid <= rd && (i == n - 1);
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask : sh

  // One command per frame, closed on a bit boundary
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nab,
                       input int nd, input int nrd, input bit dual, input int tail);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    sh(op, 8, 0, 0);
    for (int k = 2; k >= 3 - nab; k--) sh(a[8*k +: 8], 8, 0, 0);
    repeat (nd) sh(8'h00, 8, 0, 0);
    while (tx_q.size() > 0) sh(tx_q.pop_front(), 8, 0, 0);
    repeat (nrd) sh(8'h00, dual ? 4 : 8, 1, dual);
    if (tail > 0) sh(8'hFF, tail, 0, 0);
    @(posedge clk_sys);
    sck <= 1'b0;
    repeat (10) @(posedge clk_sys);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (10) @(posedge clk_sys);
  endtask : frame
endmodule : sfrpe_host

// ---- shared/sfrpe_params.svh ----
/*
  Constants of the serial flash command sequencer: opcodes, array size,
  erase region masks, reset values.
  Assumes inclusion by bare name from the core.
*/
// Behaviour
// - Read 03h, 24-bit address, data on falls
// - Address increments after every output byte
// - Read rejected while a cycle runs
// - Fast read 0Bh outputs after dummy byte
// - Dual read 3Bh drives SI and SO
// - Odd bits on SO, even on SI
// - Latch set 06h framed alone sets latch
// - Page data wraps to page start
// - Only last 256 bytes are kept
// - Unsent bytes of page stay untouched
// - Program abandoned unless ended on byte
// - Program busy flag, latch cleared early
// - Protected page is never programmed
// - Sector erase 20h wipes containing sector
// - Sector erase needs select rise after address
// - Sector erase busy flag, latch cleared
// - Protected sector is never erased
// - 32KB erase 52h selects containing block
// - 32KB erase exact end, busy, latch clear
// - 64KB erase D8h selects containing block
// - 64KB erase exact end, busy, latch clear
// - Protected blocks are never erased
// - Status 05h readable during busy
`ifndef SFRPE_PARAMS_SVH
`define SFRPE_PARAMS_SVH
`define SFRPE_OP_READ       8'h03
`define SFRPE_OP_FAST       8'h0B
`define SFRPE_OP_DUAL       8'h3B
`define SFRPE_OP_STATUS     8'h05
`define SFRPE_OP_LATCH_SET  8'h06
`define SFRPE_OP_PAGE_WRITE 8'h02
`define SFRPE_OP_SMALL_WIPE 8'h20
`define SFRPE_OP_HALF_WIPE  8'h52
`define SFRPE_OP_FULL_WIPE  8'hD8
`define SFRPE_MEM_BYTES     131072
`define SFRPE_PAGE_BYTES    256
`define SFRPE_MASK_PAGE     17'h000FF
`define SFRPE_MASK_SMALL    17'h00FFF
`define SFRPE_MASK_HALF     17'h07FFF
`define SFRPE_MASK_FULL     17'h0FFFF
`define SFRPE_MEM_TOP       18'h20000
`define SFRPE_PROT_SHIFT    5'h0A
`define SFRPE_ERASED        8'hFF
`define SFRPE_PIN_RST       3'h4
`endif

// ---- shared/sfrpe_pkg.sv ----
/*
  Types of the serial flash command sequencer.
  Assumes the params header sits beside it.
*/
package sfrpe_pkg;
  typedef enum logic [2:0] {
    SFRPE_CMD   = 3'h0,
    SFRPE_ADDR  = 3'h1,
    SFRPE_DUMMY = 3'h3,
    SFRPE_DATA  = 3'h2,
    SFRPE_PROG  = 3'h6,
    SFRPE_IGN   = 3'h7,
    SFRPE_EWAIT = 3'h5,
    SFRPE_WEN   = 3'h4
  } sfrpe_state_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sfrpe_pin_in_t;
  typedef struct packed {
    logic so;
    logic so_oe_n;
    logic si_out;
    logic si_oe_n;
  } sfrpe_pin_out_t;
  typedef struct packed {
    logic write_enable_latch;
    logic write_in_progress;
  } sfrpe_stat_t;
endpackage : sfrpe_pkg

// ---- verilog/sfrpe_core.sv ----
/*
  Serial flash device core: command decode, reads, page program, erases.
  Assumes pins come from another clock domain and the serial clock is
  well below the system clock rate.
*/
`timescale 1ns/1ps
`include "sfrpe_params.svh"
module sfrpe_core (
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  input  sfrpe_pkg::sfrpe_pin_in_t  pins_in,
  output sfrpe_pkg::sfrpe_pin_out_t pins_out,
  input  wire logic               block_protect_0,
  input  wire logic               block_protect_1,
  input  wire logic               block_protect_2,
  output sfrpe_pkg::sfrpe_stat_t  flash_status
);
  sfrpe_pkg::sfrpe_state_t state_reg;
  sfrpe_pkg::sfrpe_state_t state_next;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [7:0]  mem [0:`SFRPE_MEM_BYTES-1];
  logic [7:0]  page_buf [0:`SFRPE_PAGE_BYTES-1];
  logic [255:0] page_mask_reg;
  logic [7:0]  opcode_reg;
  logic [6:0]  in_sh_reg;
  logic [2:0]  bit_cnt_reg;
  logic [1:0]  addr_cnt_reg;
  logic [23:0] addr_reg;
  logic [7:0]  pg_ptr_reg;
  logic        prog_any_reg;
  logic        wel_reg;
  logic        busy_reg;
  logic        sw_prog_reg;
  logic [16:0] sw_addr_reg;
  logic [16:0] sw_last_reg;
  logic [7:0]  out_sh_reg;
  logic [2:0]  fcnt_reg;
  logic        so_reg;
  logic        si_out_reg;
  logic        so_oe_n_reg;
  logic        si_oe_n_reg;
  logic        cs_n;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic [23:0] addr_shift;
  logic [2:0]  bp;
  logic [7:0]  status_byte;
  logic        dual;
  logic        stat_mode;
  logic [2:0]  fstep;
  logic        byte_out_done;
  logic        enter_data;
  logic [16:0] rd_addr;
  logic [16:0] reg_mask;
  logic [16:0] reg_first;
  logic [16:0] reg_last;
  logic [17:0] prot_base;
  logic        prot;
  logic        exec_ok;
  logic        wen_ok;

  // Two flops on every pin before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= `SFRPE_PIN_RST;
      sync2_reg <= `SFRPE_PIN_RST;
      sync3_reg <= `SFRPE_PIN_RST;
    end else begin
      sync1_reg <= {pins_in.cs_n, pins_in.sck, pins_in.si};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign cs_n       = sync2_reg[2];
  assign sck_rise   = !cs_n && sync2_reg[1] && !sync3_reg[1];
  assign sck_fall   = !cs_n && !sync2_reg[1] && sync3_reg[1];
  assign cs_rise    = cs_n && !sync3_reg[2];
  assign byte_in    = {in_sh_reg, sync2_reg[0]};
  assign byte_done  = sck_rise && (bit_cnt_reg == 3'h7);
  assign addr_shift = {addr_reg[15:0], byte_in};
  assign bp         = {block_protect_2, block_protect_1, block_protect_0};
  assign status_byte = {3'h0, bp, wel_reg, busy_reg};
  assign dual       = (opcode_reg == `SFRPE_OP_DUAL);
  assign stat_mode  = (opcode_reg == `SFRPE_OP_STATUS);
  assign fstep      = dual ? 3'h2 : 3'h1;
  assign byte_out_done = sck_fall && (state_reg == sfrpe_pkg::SFRPE_DATA)
                         && ((fcnt_reg + fstep) == 3'h0);
  assign enter_data = (state_next == sfrpe_pkg::SFRPE_DATA)
                      && (state_reg != sfrpe_pkg::SFRPE_DATA);
  assign rd_addr    = (state_reg == sfrpe_pkg::SFRPE_ADDR) ? addr_shift[16:0]
                                                          : addr_reg[16:0];

  // Region touched by a program or erase, and its protection
  always_comb begin
    unique case (opcode_reg)
      `SFRPE_OP_SMALL_WIPE: reg_mask = `SFRPE_MASK_SMALL;
      `SFRPE_OP_HALF_WIPE:  reg_mask = `SFRPE_MASK_HALF;
      `SFRPE_OP_FULL_WIPE:  reg_mask = `SFRPE_MASK_FULL;
      default:              reg_mask = `SFRPE_MASK_PAGE;
    endcase
  end

  assign reg_first = addr_reg[16:0] & ~reg_mask;
  assign reg_last  = addr_reg[16:0] | reg_mask;
  assign prot_base = `SFRPE_MEM_TOP - (18'h1 << ({2'h0, bp} + `SFRPE_PROT_SHIFT));
  assign prot      = (bp != 3'h0) && ({1'b0, reg_last} >= prot_base);
  assign exec_ok   = cs_rise && (bit_cnt_reg == 3'h0) && wel_reg
                     && !busy_reg && !prot
                     && ((state_reg == sfrpe_pkg::SFRPE_EWAIT)
                     || ((state_reg == sfrpe_pkg::SFRPE_PROG) && prog_any_reg));
  assign wen_ok    = cs_rise && (state_reg == sfrpe_pkg::SFRPE_WEN)
                     && (bit_cnt_reg == 3'h0) && !busy_reg;

  // Command sequencing
  always_comb begin
    state_next = state_reg;
    if (cs_n) begin
      state_next = sfrpe_pkg::SFRPE_CMD;
    end else if (sck_rise && ((state_reg == sfrpe_pkg::SFRPE_EWAIT)
                 || (state_reg == sfrpe_pkg::SFRPE_WEN))) begin
      state_next = sfrpe_pkg::SFRPE_IGN;
    end else if (byte_done) begin
      unique case (state_reg)
        sfrpe_pkg::SFRPE_CMD: begin
          unique case (byte_in)
            `SFRPE_OP_READ, `SFRPE_OP_FAST, `SFRPE_OP_DUAL,
            `SFRPE_OP_PAGE_WRITE, `SFRPE_OP_SMALL_WIPE,
            `SFRPE_OP_HALF_WIPE, `SFRPE_OP_FULL_WIPE: begin
              state_next = busy_reg ? sfrpe_pkg::SFRPE_IGN
                                    : sfrpe_pkg::SFRPE_ADDR;
            end
            `SFRPE_OP_STATUS:    state_next = sfrpe_pkg::SFRPE_DATA;
            `SFRPE_OP_LATCH_SET: state_next = sfrpe_pkg::SFRPE_WEN;
            default:             state_next = sfrpe_pkg::SFRPE_IGN;
          endcase
        end
        sfrpe_pkg::SFRPE_ADDR: begin
          if (addr_cnt_reg == 2'h2) begin
            unique case (opcode_reg)
              `SFRPE_OP_READ:       state_next = sfrpe_pkg::SFRPE_DATA;
              `SFRPE_OP_PAGE_WRITE: state_next = sfrpe_pkg::SFRPE_PROG;
              `SFRPE_OP_FAST, `SFRPE_OP_DUAL: begin
                state_next = sfrpe_pkg::SFRPE_DUMMY;
              end
              default:              state_next = sfrpe_pkg::SFRPE_EWAIT;
            endcase
          end
        end
        sfrpe_pkg::SFRPE_DUMMY: state_next = sfrpe_pkg::SFRPE_DATA;
        default: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sfrpe_pkg::SFRPE_CMD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Serial input shifting and address capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opcode_reg    <= 8'h00;
      in_sh_reg     <= 7'h00;
      bit_cnt_reg   <= 3'h0;
      addr_cnt_reg  <= 2'h0;
      addr_reg      <= 24'h000000;
      pg_ptr_reg    <= 8'h00;
      prog_any_reg  <= 1'b0;
      page_mask_reg <= '0;
    end else if (cs_n) begin
      bit_cnt_reg  <= 3'h0;
      addr_cnt_reg <= 2'h0;
    end else if (sck_rise) begin
      in_sh_reg   <= byte_in[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        if (state_reg == sfrpe_pkg::SFRPE_CMD) begin
          opcode_reg   <= byte_in;
          prog_any_reg <= 1'b0;
        end
        if (state_reg == sfrpe_pkg::SFRPE_ADDR) begin
          addr_reg     <= addr_shift;
          addr_cnt_reg <= addr_cnt_reg + 2'h1;
          pg_ptr_reg   <= addr_shift[7:0];
          page_mask_reg <= '0;
        end
        if (state_reg == sfrpe_pkg::SFRPE_PROG) begin
          pg_ptr_reg   <= pg_ptr_reg + 8'h01;
          prog_any_reg <= 1'b1;
          page_mask_reg[pg_ptr_reg] <= 1'b1;
        end
      end
    end else if (byte_out_done && !stat_mode) begin
      addr_reg <= addr_reg + 24'h000001;
    end
  end

  // Later bytes overwrite earlier ones at the same page offset
  always_ff @(posedge clk_sys) begin
    if (byte_done && (state_reg == sfrpe_pkg::SFRPE_PROG)) begin
      page_buf[pg_ptr_reg] <= byte_in;
    end
  end

  // Output shifting on serial clock falls
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_sh_reg  <= 8'h00;
      fcnt_reg    <= 3'h0;
      so_reg      <= 1'b0;
      si_out_reg  <= 1'b0;
      so_oe_n_reg <= 1'b1;
      si_oe_n_reg <= 1'b1;
    end else if (cs_n) begin
      so_oe_n_reg <= 1'b1;
      si_oe_n_reg <= 1'b1;
    end else if (enter_data) begin
      out_sh_reg  <= stat_mode || (state_reg == sfrpe_pkg::SFRPE_CMD) ? status_byte
                                                                       : mem[rd_addr];
      fcnt_reg    <= 3'h0;
      so_oe_n_reg <= 1'b0;
      si_oe_n_reg <= !dual || (state_reg == sfrpe_pkg::SFRPE_CMD);
    end else if (sck_fall && (state_reg == sfrpe_pkg::SFRPE_DATA)) begin
      so_reg     <= out_sh_reg[7];
      si_out_reg <= out_sh_reg[6];
      fcnt_reg   <= fcnt_reg + fstep;
      if (byte_out_done) begin
        out_sh_reg <= stat_mode ? status_byte : mem[addr_reg[16:0] + 17'h00001];
      end else if (dual) begin
        out_sh_reg <= {out_sh_reg[5:0], 2'h0};
      end else begin
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Write enable latch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wel_reg <= 1'b0;
    end else if (exec_ok) begin
      wel_reg <= 1'b0;
    end else if (wen_ok) begin
      wel_reg <= 1'b1;
    end
  end

  // Self-timed sweep over the affected region
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg    <= 1'b0;
      sw_prog_reg <= 1'b0;
      sw_addr_reg <= 17'h00000;
      sw_last_reg <= 17'h00000;
    end else if (exec_ok) begin
      busy_reg    <= 1'b1;
      sw_prog_reg <= (state_reg == sfrpe_pkg::SFRPE_PROG);
      sw_addr_reg <= reg_first;
      sw_last_reg <= reg_last;
    end else if (busy_reg) begin
      sw_addr_reg <= sw_addr_reg + 17'h00001;
      if (sw_addr_reg == sw_last_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (busy_reg) begin
      if (!sw_prog_reg) begin
        mem[sw_addr_reg] <= `SFRPE_ERASED;
      end else if (page_mask_reg[sw_addr_reg[7:0]]) begin
        mem[sw_addr_reg] <= mem[sw_addr_reg] & page_buf[sw_addr_reg[7:0]];
      end
    end
  end

  assign pins_out.so      = so_reg;
  assign pins_out.so_oe_n = so_oe_n_reg;
  assign pins_out.si_out  = si_out_reg;
  assign pins_out.si_oe_n = si_oe_n_reg;
  assign flash_status.write_enable_latch = wel_reg;
  assign flash_status.write_in_progress  = busy_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_START_BUSY: assert property (exec_ok |=> busy_reg && !wel_reg)
    else $error("Cycle start did not raise busy and clear latch");
  AST_PROT_BLOCK: assert property (cs_rise && prot && !busy_reg |=> !busy_reg)
    else $error("Protected region started a cycle");
  AST_READ_REJECT: assert property (byte_done && state_reg == sfrpe_pkg::SFRPE_CMD
    && byte_in == `SFRPE_OP_READ && busy_reg |=> state_reg == sfrpe_pkg::SFRPE_IGN)
    else $error("Read accepted while busy");
  AST_CS_IDLE: assert property (cs_n |=> state_reg == sfrpe_pkg::SFRPE_CMD)
    else $error("Interface not idle after select rise");
  AST_ADDR_STEP: assert property (byte_out_done && !stat_mode
    |=> addr_reg == $past(addr_reg) + 24'h000001)
    else $error("Read address did not advance");
  AST_MSB_FIRST: assert property (sck_fall && state_reg == sfrpe_pkg::SFRPE_DATA
    && !enter_data |=> so_reg == $past(out_sh_reg[7]))
    else $error("Output bit not most significant");
  AST_DUAL_PAIR: assert property (sck_fall && state_reg == sfrpe_pkg::SFRPE_DATA
    && dual |=> si_out_reg == $past(out_sh_reg[6]) && !si_oe_n_reg)
    else $error("Dual pair order wrong");
  AST_ERASE_ONES: assert property (busy_reg && !sw_prog_reg
    |=> mem[$past(sw_addr_reg)] == `SFRPE_ERASED)
    else $error("Erased byte not all ones");
  AST_WEL_SET: assert property (wen_ok |=> wel_reg)
    else $error("Latch not set by framed command");
  AST_ABANDON: assert property (cs_rise && state_reg == sfrpe_pkg::SFRPE_PROG
    && bit_cnt_reg != 3'h0 && !busy_reg |=> !busy_reg)
    else $error("Partial byte program executed");
endmodule : sfrpe_core
